// ===== verilog/external_wait_state_generator.sv
// module: register file and bus-cycle stretcher of the external wait-state generator
//
// Function
// [R1] extended decode bit 15 chooses how program fields map to addresses.
// [R2] io accesses use bits 14..12 as base wait count.
// [R3] upper data half uses bits 11..9 as base wait count.
// [R4] lower data half uses bits 8..6 as base wait count.
// [R5] upper program field covers upper page half, or upper extended half.
// [R6] lower program field covers lower page half, or lower extended half.
// [R7] multiplier bit doubles every base count, up to fourteen.
// [R8] control bits 15..1 ignore writes and read zero.
// [R9] after reset every external access gets seven wait states.
// [R10] each access taken while idle decodes its range and stalls base times multiplier cycles.
`timescale 1ns/1ps
module external_wait_state_generator
	import wait_state_pkg::*;
(
	input  wire logic     clk_in,
	input  wire logic     reset_in,
	input  wire reg_req_t reg_in,
	input  wire access_t  access_in,
	output logic [15:0]   rdata_out,
	output logic          busy_out,
	output logic          done_out,
	output logic [3:0]    wait_count_out
);
	// ==========================================
	// elaboration checks
	localparam int N_FIELDS             = 5;
	localparam int FIELD_LSB [N_FIELDS] = '{IO_LSB, DATA_HI_LSB, DATA_LO_LSB, PROG_HI_LSB, PROG_LO_LSB};

	// a doubled seven has to fit the reported count, or fourteen would wrap to a short stall
	if (COUNT_W != FIELD_W + 1) begin
		$error("count width must be one bit wider than a base field");
	end
	if (COUNT_W != 4) begin
		$error("wait count port is four bits wide");
	end
	if (FIELD_W != 3) begin
		$error("range decoder hands over a three-bit field");
	end
	if (MULT_BIT != 0) begin
		$error("control read-back expects the multiplier at bit 0");
	end
	if (MULT_RESET != 1'b0) begin
		$error("multiplier must come out of reset clear");
	end
	if (SELECT_ADDR == CONTROL_ADDR) begin
		$error("select and control registers need distinct addresses");
	end
	if (EXT_DECODE_BIT != 15) begin
		$error("extended decode bit must be the top bit of the select register");
	end
	if (SELECT_RESET[EXT_DECODE_BIT] != 1'b0) begin
		$error("extended decode must come out of reset clear");
	end
	if (IO_LSB + FIELD_W != EXT_DECODE_BIT) begin
		$error("io field must end just below the extended decode bit");
	end
	// the page split has to lie below the extended split, or both decodes would agree
	if (PAGE_SPLIT_BIT >= XPROG_SPLIT_BIT) begin
		$error("page split must lie below the extended split");
	end
	if (DATA_SPLIT_BIT != 15) begin
		$error("data split must halve a sixteen-bit space");
	end
	for (genvar g = 0; g < N_FIELDS; g++) begin : field_checks
		if (FIELD_LSB[g] != PROG_LO_LSB + FIELD_W * (N_FIELDS - 1 - g)) begin
			$error("base fields must be packed below the extended decode bit");
		end
		if (SELECT_RESET[FIELD_LSB[g] +: FIELD_W] != 3'h7) begin // [R9]
			$error("every base field must reset to seven");
		end
	end

	// ==========================================
	// state
	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_WAIT = 2'b10
	} phase_t;

	typedef struct packed {
		phase_t      phase;
		logic [15:0] select;
		logic        mult;
		logic [3:0]  remain;
		logic [15:0] rdata;
		logic        busy;
		logic        done;
		logic [3:0]  count;
	} state_t;

	state_t     s_q;
	state_t     s_d;
	logic [2:0] base;
	logic [3:0] total;
	logic       take;
	logic       last_wait;

	wait_range_decode u_decode (
		.access_in (access_in),
		.select_in (s_q.select),
		.base_out  (base)
	);

	// ==========================================
	// decode helpers
	// one address compare serves both the write and the read path
	function automatic logic hits(
		input logic [7:0] addr,
		input logic [7:0] target
	);
		hits = (addr == target);
	endfunction

	// doubling is a shift, so the stretch needs no multiplier
	function automatic logic [3:0] scaled(
		input logic [2:0] base_count,
		input logic       doubled
	);
		scaled = doubled ? {base_count, 1'b0} : {1'b0, base_count}; // [R7]
	endfunction

	function automatic logic [15:0] control_view(
		input logic doubled
	);
		control_view = {15'h0000, doubled}; // [R8]
	endfunction

	// unmapped addresses read as zero
	function automatic logic [15:0] read_mux(
		input logic [7:0]  addr,
		input logic [15:0] select,
		input logic        doubled
	);
		read_mux = 16'h0000;
		if (hits(addr, SELECT_ADDR)) begin
			read_mux = select;
		end
		if (hits(addr, CONTROL_ADDR)) begin
			read_mux = control_view(doubled);
		end
	endfunction

	// ==========================================
	// handshake terms
	// an access is taken only while idle; a request during a stall is dropped
	assign take      = access_in.valid && (s_q.phase == ST_IDLE);
	assign last_wait = (s_q.remain == 4'h1);

	// ==========================================
	// next state
	always_comb begin
		s_d      = s_q;
		s_d.done = 1'b0;
		total    = scaled(base, s_q.mult); // [R7]

		// register writes; reserved control bits never reach a flip-flop
		if (reg_in.write) begin
			if (hits(reg_in.addr, SELECT_ADDR)) begin
				s_d.select = reg_in.wdata; // [R1]
			end
			if (hits(reg_in.addr, CONTROL_ADDR)) begin
				s_d.mult = reg_in.wdata[MULT_BIT]; // [R8]
			end
		end

		// a read in the write cycle returns the old contents
		if (reg_in.read) begin
			s_d.rdata = read_mux(reg_in.addr, s_q.select, s_q.mult); // [R8]
		end

		// access sequencing
		case (s_q.phase)
			ST_IDLE: begin
				if (take) begin
					s_d.count = total;
					// zero wait states pulse done in the cycle after issue, without stalling
					if (total == 4'h0) begin
						s_d.done = 1'b1;
					end else begin
						s_d.remain = total; // [R10]
						s_d.busy   = 1'b1;
						s_d.phase  = ST_WAIT;
					end
				end
			end
			ST_WAIT: begin
				s_d.remain = s_q.remain - 4'h1; // [R10]
				// the last wait state ends the stall and pulses done
				if (last_wait) begin
					s_d.busy  = 1'b0;
					s_d.done  = 1'b1;
					s_d.phase = ST_IDLE;
				end
			end
			default: begin
				s_d.phase = ST_IDLE;
				s_d.busy  = 1'b0;
			end
		endcase
	end

	// ==========================================
	// registers
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			s_q        <= '0;
			s_q.phase  <= ST_IDLE;
			// seven wait states on every range until software writes the select or control register
			s_q.select <= SELECT_RESET; // [R9]
			s_q.mult   <= MULT_RESET;
		end else begin
			s_q <= s_d;
		end
	end

	// ==========================================
	// outputs, each straight from its flip-flop
	assign rdata_out      = s_q.rdata;
	assign busy_out       = s_q.busy;
	assign done_out       = s_q.done;
	assign wait_count_out = s_q.count;
endmodule

// ===== verilog/wait_state_pkg.sv
// package: register map, field layout and reset values of the external wait-state generator
package wait_state_pkg;
	// ==========================================
	// register map
	localparam logic [7:0]  SELECT_ADDR       = 8'h28;
	localparam logic [7:0]  CONTROL_ADDR      = 8'h2b;
	// ==========================================
	// field positions
	localparam int          EXT_DECODE_BIT    = 15;
	localparam int          IO_LSB            = 12;
	localparam int          DATA_HI_LSB       = 9;
	localparam int          DATA_LO_LSB       = 6;
	localparam int          PROG_HI_LSB       = 3;
	localparam int          PROG_LO_LSB       = 0;
	localparam int          MULT_BIT          = 0;
	localparam int          FIELD_W           = 3;
	localparam int          COUNT_W           = 4;
	// ==========================================
	// reset values
	localparam logic [15:0] SELECT_RESET      = 16'h7fff;
	localparam logic        MULT_RESET        = 1'b0;
	// ==========================================
	// address split points
	localparam int          DATA_SPLIT_BIT    = 15;
	localparam int          XPROG_SPLIT_BIT   = 22;
	localparam int          PAGE_SPLIT_BIT    = 15;

	typedef enum logic [1:0] {
		SPACE_PROGRAM = 2'h0,
		SPACE_DATA    = 2'h1,
		SPACE_IO      = 2'h2
	} space_t;

	typedef struct packed {
		logic        valid;
		space_t      space;
		logic [22:0] addr;
	} access_t;

	typedef struct packed {
		logic        write;
		logic        read;
		logic [7:0]  addr;
		logic [15:0] wdata;
	} reg_req_t;
endpackage

// ===== verilog/wait_range_decode.sv
// module: picks the base wait-state field for one external access
`timescale 1ns/1ps
module wait_range_decode
	import wait_state_pkg::*;
(
	input  wire access_t      access_in,
	input  wire logic [15:0]  select_in,
	output logic [2:0]        base_out
);
	function automatic logic [2:0] field_at(input logic [15:0] r, input int lsb);
		field_at = r[lsb +: FIELD_W];
	endfunction

	logic upper;

	always_comb begin
		upper    = 1'b0;
		base_out = field_at(select_in, PROG_LO_LSB);
		case (access_in.space)
			SPACE_IO: begin
				base_out = field_at(select_in, IO_LSB); // [R2]
			end
			SPACE_DATA: begin
				upper    = access_in.addr[DATA_SPLIT_BIT];
				base_out = upper ? field_at(select_in, DATA_HI_LSB) : field_at(select_in, DATA_LO_LSB); // [R3] [R4]
			end
			SPACE_PROGRAM: begin
				// extended decode splits the whole space in halves, otherwise each page in halves
				upper    = select_in[EXT_DECODE_BIT] ? access_in.addr[XPROG_SPLIT_BIT]
					: access_in.addr[PAGE_SPLIT_BIT]; // [R1]
				base_out = upper ? field_at(select_in, PROG_HI_LSB) : field_at(select_in, PROG_LO_LSB); // [R5] [R6]
			end
			default: begin
				base_out = field_at(select_in, PROG_LO_LSB);
			end
		endcase
	end
endmodule

// ===== test/bus_cycle_meter.sv
// partner: external device, measures each stretched bus cycle
`timescale 1ns/1ps
module bus_cycle_meter (
	input  wire logic       clk_in,
	input  wire logic       start_in,
	input  wire logic       done_in,
	output logic [4:0]      cycles_out
);
	// ==========
	// strobe length seen by the device
	logic [4:0] run_q;
	always_ff @(posedge clk_in) begin
		run_q <= start_in ? 5'h1 : run_q + 5'h1;
		if (done_in) cycles_out <= run_q;
	end
endmodule

// ===== test/external_wait_state_generator_properties.sv
// checker: port timing of the wait-state generator
`timescale 1ns/1ps
module external_wait_state_generator_properties
	import wait_state_pkg::*;
(
	input wire logic        clk_in,
	input wire logic        reset_in,
	input wire reg_req_t    reg_in,
	input wire access_t     access_in,
	input wire logic [15:0] rdata_out,
	input wire logic        busy_out,
	input wire logic        done_out,
	input wire logic [3:0]  wait_count_out
);
	// ==========
	default clocking @(posedge clk_in); endclocking
	default disable iff (reset_in);
	wire tk = access_in.valid && !busy_out;
	property p_b; tk |=> busy_out == (wait_count_out != 4'h0); endproperty
	property p_z; tk ##1 wait_count_out == 4'h0 |-> done_out; endproperty
	property p_e; $fell(busy_out) |-> done_out; endproperty
	property p_p; done_out |=> !done_out; endproperty
	property p_m; wait_count_out <= 4'he; endproperty
	property p_w; $rose(busy_out) |-> ##[1:14] done_out; endproperty
	property p_h; busy_out && $past(busy_out) |-> $stable(wait_count_out); endproperty
	property p_c; reg_in.read && reg_in.addr == CONTROL_ADDR |=> rdata_out[15:1] == 15'h0; endproperty
	a_b: assert property (p_b) else $error("busy wrong");
	a_z: assert property (p_z) else $error("no done");
	a_e: assert property (p_e) else $error("end wrong");
	a_p: assert property (p_p) else $error("long done");
	a_m: assert property (p_m) else $error("count high");
	a_w: assert property (p_w) else $error("late done");
	a_h: assert property (p_h) else $error("count moved");
	a_c: assert property (p_c) else $error("control bits");
	c_z: cover property (tk ##1 done_out);
	c_m: cover property (done_out && wait_count_out == 4'he);
	c_c: cover property (reg_in.write && reg_in.addr == CONTROL_ADDR);
endmodule
bind external_wait_state_generator external_wait_state_generator_properties chk_inst (
	.clk_in         (clk_in),
	.reset_in       (reset_in),
	.reg_in         (reg_in),
	.access_in      (access_in),
	.rdata_out      (rdata_out),
	.busy_out       (busy_out),
	.done_out       (done_out),
	.wait_count_out (wait_count_out)
);

// ===== test/tb_external_wait_state_generator.sv
// testbench: registers and bus-cycle stretching
`timescale 1ns/1ps
`define CHK(nm, e, s) begin tests_run++; if ((s) !== (e)) begin n_mismatch++; \
	$display("Error %s expected %h seen %h", nm, e, s); end end
module tb_external_wait_state_generator;
	import wait_state_pkg::*;
	// ==========
	logic        clk_in = 0;
	logic        reset_in = 1;
	reg_req_t    reg_in = '0;
	access_t     access_in = '0;
	logic [15:0] rdata_out;
	logic        busy_out, done_out;
	logic [3:0]  wait_count_out;
	logic [4:0]  cyc;
	int          n_mismatch = 0, tests_run = 0;
	always #10 clk_in = ~clk_in;
	external_wait_state_generator external_wait_state_generator_inst (.*);
	bus_cycle_meter bus_cycle_meter_inst (.clk_in(clk_in), .start_in(access_in.valid), .done_in(done_out),
		.cycles_out(cyc));
	task automatic wrap_up();
		$display("mismatches %0d checks %0d", n_mismatch, tests_run);
		if (n_mismatch == 0 && tests_run > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic rq(input logic w, input logic [7:0] a, input logic [15:0] d);
		@(negedge clk_in) reg_in = '{w, !w, a, d};
		@(negedge clk_in) reg_in = '0;
	endtask
	task automatic acc(input space_t s, input logic [22:0] a, input logic [3:0] n);
		int i;
		@(negedge clk_in) access_in = '{1'b1, s, a};
		@(negedge clk_in) access_in = '0;
		`CHK("busy", n != 4'h0, busy_out)
		for (i = 0; i < 20 && done_out !== 1'b1; i++) @(negedge clk_in);
		if (i == 20) begin
			n_mismatch++;
			wrap_up();
		end
		@(negedge clk_in);
		`CHK("wait count", n, wait_count_out)
		`CHK("cycle length", {1'b0, n} + 5'h1, cyc)
	endtask
	// ==========
	// reset state, then the doubled maximum
	task automatic reset_and_peak();
		rq(0, SELECT_ADDR, 0);
		`CHK("select", SELECT_RESET, rdata_out)
		acc(SPACE_DATA, 23'h1234, 4'h7);
		rq(1, CONTROL_ADDR, 16'hffff);
		rq(0, CONTROL_ADDR, 0);
		`CHK("control", 16'h0001, rdata_out)
		acc(SPACE_IO, 23'hffff, 4'he);
	endtask
	// at least one access per range, boundary addresses
	task automatic ranges(input logic x, input logic m);
		space_t      sp[7] = '{SPACE_IO, SPACE_DATA, SPACE_DATA, SPACE_PROGRAM, SPACE_PROGRAM, SPACE_PROGRAM,
			SPACE_PROGRAM};
		logic [22:0] ad[7] = '{23'h0, 23'h8000, 23'h7fff, 23'h408000, 23'h3f8000, 23'h7f7fff, 23'h0};
		logic [3:0]  b[7] = '{1, 2, 3, 4, x ? 5 : 4, x ? 4 : 5, 5};
		rq(1, SELECT_ADDR, {x, 15'h14e5});
		rq(1, CONTROL_ADDR, {15'h0, m});
		rq(0, SELECT_ADDR, 0);
		`CHK("select", {x, 15'h14e5}, rdata_out)
		for (int i = 0; i < 7; i++) acc(sp[i], ad[i], b[i] << m);
	endtask
	// zero base counts finish without a stall, with the multiplier set
	task automatic zero_wait();
		rq(1, SELECT_ADDR, 16'h0000);
		rq(1, CONTROL_ADDR, 16'h0001);
		acc(SPACE_IO, 23'h0, 4'h0);
		acc(SPACE_DATA, 23'hffff, 4'h0);
	endtask
	// reset in mid-run restores seven wait states everywhere
	task automatic mid_reset();
		rq(1, SELECT_ADDR, 16'h8000);
		rq(1, CONTROL_ADDR, 16'h0001);
		@(negedge clk_in);
		reset_in = 1;
		repeat (2) @(negedge clk_in);
		reset_in = 0;
		rq(0, SELECT_ADDR, 0);
		`CHK("select", SELECT_RESET, rdata_out)
		rq(0, CONTROL_ADDR, 0);
		`CHK("control", {15'h0000, MULT_RESET}, rdata_out)
		acc(SPACE_PROGRAM, 23'h7fffff, 4'h7);
	endtask
	initial begin
		repeat (16) @(negedge clk_in);
		reset_in = 0;
		reset_and_peak();
		ranges(1'b0, 1'b1);
		ranges(1'b1, 1'b0);
		zero_wait();
		mid_reset();
		wrap_up();
	end
endmodule
